/* File: rtl/csp_regs.svh */
`ifndef CSP_REGS_SVH
`define CSP_REGS_SVH
// byte addresses on the register bus
`define CSP_ADDR_SYSTEM_CLOCK_SOURCE_SEL 8'h8f
`define CSP_ADDR_WAKE   8'h9f
`define CSP_ADDR_PMODE  8'hc4
`define CSP_ADDR_PCTRL  8'h87
// reset values
`define CSP_RST_SYSTEM_CLOCK_SOURCE_SEL  8'h0c
`define CSP_RST_WAKE    8'hff
`define CSP_RST_PMODE   8'h40
`define CSP_RST_PCTRL   8'h00
// field positions
`define CSP_F_SEL_LO    0
`define CSP_F_SETL_LO   2
`define CSP_F_DIV_LO    4
`define CSP_F_SWB       5
`define CSP_F_CD0       6
`define CSP_F_CD1       7
`define CSP_F_IDLE      4
`define CSP_F_STOP      5
`define CSP_F_SLEEP     6
// settle base count in slow oscillator cycles
`define CSP_SETTLE_BASE 8'h10
// reduced speed divider
`define CSP_RSM_DIV     9'h101
`endif

/* File: rtl/csp_pkg.sv */
package csp_pkg;
  typedef enum logic [2:0] {CSP_RUN, CSP_IDLE, CSP_STOP, CSP_SETTLE} csp_state_e;
  typedef struct packed {
    logic [3:0] prediv;
    logic [1:0] settle;
    logic [1:0] source;
  } csp_system_clock_source_sel_s;
  typedef struct packed {
    logic cd1;
    logic cd0;
    logic autoRet;
  } csp_pmode_s;
endpackage : csp_pkg

/* File: rtl/csp_clk_div.sv */
`timescale 1ns/100ps
`default_nettype none
`include "csp_regs.svh"
// enable pulse generator for the fast oscillator pre-divider
module csp_clk_div
  import csp_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // control
  input  wire logic [3:0] prediv,
  // output
  output var  logic       tick
);
  logic [11:0] count;
  logic [11:0] limit;

  function automatic logic [11:0] divLimit(input logic [3:0] code);
    unique case (code)
      4'h6:    divLimit = 12'h00b;
      4'h7:    divLimit = 12'h00d;
      4'h8:    divLimit = 12'h00f;
      4'h9:    divLimit = 12'h01f;
      4'ha:    divLimit = 12'h03f;
      4'hb:    divLimit = 12'h07f;
      4'hc:    divLimit = 12'h0ff;
      4'hd:    divLimit = 12'h1ff;
      4'he:    divLimit = 12'h3ff;
      4'hf:    divLimit = 12'h7ff;
      default: divLimit = 12'h000;
    endcase
  endfunction : divLimit

  assign limit = divLimit(prediv);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 12'h000;
      tick  <= 1'b0;
    end else if (count >= limit) begin
      count <= 12'h000;
      tick  <= 1'b1;
    end else begin
      count <= count + 12'h001;
      tick  <= 1'b0;
    end
  end
endmodule : csp_clk_div
`default_nettype wire

/* File: rtl/csp_clock_power.sv */
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "csp_regs.svh"
module csp_clock_power
  import csp_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        slowTick,
  input  wire logic        wdtReset,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  // interrupt sources, bit order 8,7,6,4,3,2,1,0
  input  wire logic [1:0]  extPinIrq,
  input  wire logic [5:0]  periphIrqFlag,
  input  wire logic [7:0]  irqEnabled,
  input  wire logic [7:0]  irqNotBlocked,
  input  wire logic        asyncWakeIrq,
  input  wire logic        primaryUartRx,
  input  wire logic        uart0RxEnable,
  input  wire logic        uartTxLoad,
  // clock enables out
  output var  logic        coreClkEn,
  output var  logic        periphClkEn,
  output var  logic        fastOscEn,
  output var  logic        mainRegEn,
  output var  logic        cpuHold,
  output var  logic        slowSelected
);
  // ==========================================================
  // input synchronisers
  logic [9:0] syncA;
  logic [9:0] syncB;
  logic [9:0] syncPrev;
  logic [9:0] rawIn;
  assign rawIn = {primaryUartRx, asyncWakeIrq, periphIrqFlag, ~extPinIrq};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA    <= 10'h3ff;
      syncB    <= 10'h3ff;
      syncPrev <= 10'h3ff;
    end else begin
      syncA    <= rawIn;
      syncB    <= syncA;
      syncPrev <= syncB;
    end
  end

  logic [7:0] irqRise;
  logic       rxFall;
  logic       asyncRise;
  assign irqRise   = syncB[7:0] & ~syncPrev[7:0];
  assign asyncRise = syncB[8] & ~syncPrev[8];
  assign rxFall    = ~syncB[9] & syncPrev[9];

  // ==========================================================
  // registers
  csp_system_clock_source_sel_s system_clock_source_sel;
  csp_pmode_s  pmode;
  logic [7:0]  stop_wake_source_mask;
  logic        idleBit;
  logic        stopBit;
  logic        sleepBit;
  csp_state_e  state;
  logic        wakeEvent;
  logic        idleExit;
  logic        settleDone;

  logic busReq;
  logic busWr;
  assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign busWr  = busReq & wb_we_i & wb_sel_i[0];

  function automatic logic isAddr(input logic [7:0] a, input logic [7:0] ref_a);
    isAddr = (a == ref_a);
  endfunction : isAddr

  logic wrClk;
  logic wrWake;
  logic wrPmode;
  logic wrPctrl;
  assign wrClk   = busWr & isAddr(wb_adr_i, `CSP_ADDR_SYSTEM_CLOCK_SOURCE_SEL);
  assign wrWake  = busWr & isAddr(wb_adr_i, `CSP_ADDR_WAKE);
  assign wrPmode = busWr & isAddr(wb_adr_i, `CSP_ADDR_PMODE);
  assign wrPctrl = busWr & isAddr(wb_adr_i, `CSP_ADDR_PCTRL);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      system_clock_source_sel <= csp_system_clock_source_sel_s'(`CSP_RST_SYSTEM_CLOCK_SOURCE_SEL);
    end else if (state == CSP_STOP && wakeEvent) begin
      system_clock_source_sel.source <= 2'b00;
    end else if (wrClk) begin
      system_clock_source_sel <= csp_system_clock_source_sel_s'(wb_dat_i[7:0]);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_wake_source_mask <= `CSP_RST_WAKE;
    end else if (wrWake) begin
      stop_wake_source_mask <= wb_dat_i[7:0];
    end
  end

  // reduced speed mode control
  logic rsmActive;
  logic autoReturn;
  assign rsmActive  = pmode.cd1 & pmode.cd0;
  assign autoReturn = pmode.autoRet & rsmActive &
                      ((|(irqRise & irqEnabled & irqNotBlocked)) |
                       (rxFall & uart0RxEnable) |
                       uartTxLoad);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pmode <= csp_pmode_s'(3'(`CSP_RST_PMODE >> `CSP_F_SWB));
    end else if (wdtReset) begin
      pmode.cd1 <= 1'b0;
    end else if (autoReturn) begin
      pmode.cd1 <= 1'b0;
    end else if (wrPmode) begin
      pmode <= csp_pmode_s'(wb_dat_i[`CSP_F_CD1:`CSP_F_SWB]);
    end
  end

  // power control bits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      idleBit  <= 1'b0;
      stopBit  <= 1'b0;
      sleepBit <= 1'b0;
    end else if (wdtReset) begin
      idleBit  <= 1'b0;
      stopBit  <= 1'b0;
      sleepBit <= 1'b0;
    end else if (state == CSP_IDLE && idleExit) begin
      idleBit <= 1'b0;
    end else if (state == CSP_STOP && wakeEvent) begin
      stopBit  <= 1'b0;
      sleepBit <= 1'b0;
    end else if (wrPctrl && state == CSP_RUN) begin
      idleBit  <= wb_dat_i[`CSP_F_IDLE];
      stopBit  <= wb_dat_i[`CSP_F_STOP];
      sleepBit <= wb_dat_i[`CSP_F_SLEEP];
    end
  end

  // ==========================================================
  // wake and idle exit; stop wake takes the masked, enabled pin and flag sources plus the async source
  assign wakeEvent = (|(irqRise & stop_wake_source_mask & irqEnabled))
                     | asyncRise;
  assign idleExit  = |(irqRise & irqEnabled);

  // ==========================================================
  // power state machine
  logic [7:0] settleCnt;
  logic [7:0] settleLimit;
  assign settleLimit = `CSP_SETTLE_BASE << system_clock_source_sel.settle;
  assign settleDone  = (settleCnt >= settleLimit - 8'h01) && slowTick;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= CSP_SETTLE;
    end else begin
      unique case (state)
        CSP_RUN: begin
          if (stopBit) begin
            state <= CSP_STOP;
          end else if (idleBit) begin
            state <= CSP_IDLE;
          end
        end
        CSP_IDLE: begin
          if (idleExit) begin
            state <= CSP_RUN;
          end
        end
        CSP_STOP: begin
          if (wakeEvent) begin
            state <= sleepBit ? CSP_SETTLE : CSP_RUN;
          end
        end
        CSP_SETTLE: begin
          if (settleDone) begin
            state <= CSP_RUN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      settleCnt <= 8'h00;
    end else if (state != CSP_SETTLE) begin
      settleCnt <= 8'h00;
    end else if (slowTick) begin
      settleCnt <= settleCnt + 8'h01;
    end
  end

  // ==========================================================
  // clock enables: single-cycle enables on one clock keep gating glitch-free
  logic divTick;
  csp_clk_div u_div (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .prediv   (system_clock_source_sel.prediv),
    .tick     (divTick)
  );

  logic [8:0] rsmCnt;
  logic       rsmTick;
  assign rsmTick = (rsmCnt == `CSP_RSM_DIV - 9'h001);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsmCnt <= 9'h000;
    end else if (!rsmActive || rsmTick) begin
      rsmCnt <= 9'h000;
    end else begin
      rsmCnt <= rsmCnt + 9'h001;
    end
  end

  logic srcTick;
  always_comb begin
    unique case (system_clock_source_sel.source)
      2'b00:   srcTick = divTick;
      2'b01:   srcTick = 1'b1;
      default: srcTick = slowTick;
    endcase
  end

  logic running;
  assign running = (state == CSP_RUN);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      coreClkEn    <= 1'b0;
      periphClkEn  <= 1'b0;
      fastOscEn    <= 1'b1;
      mainRegEn    <= 1'b1;
      cpuHold      <= 1'b1;
      slowSelected <= 1'b0;
    end else begin
      coreClkEn    <= running & srcTick & (!rsmActive | rsmTick);
      periphClkEn  <= (running | state == CSP_IDLE) & srcTick;
      fastOscEn    <= (state != CSP_STOP);
      mainRegEn    <= !(state == CSP_STOP && sleepBit);
      cpuHold      <= !running;
      slowSelected <= system_clock_source_sel.source[1];
    end
  end

  // ==========================================================
  // bus read and ack
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= busReq;
      if (busReq) begin
        if (isAddr(wb_adr_i, `CSP_ADDR_SYSTEM_CLOCK_SOURCE_SEL)) begin
          wb_dat_o <= {24'h000000, system_clock_source_sel.prediv, 2'b00, system_clock_source_sel.source};
        end else if (isAddr(wb_adr_i, `CSP_ADDR_WAKE)) begin
          wb_dat_o <= {24'h000000, stop_wake_source_mask};
        end else if (isAddr(wb_adr_i, `CSP_ADDR_PMODE)) begin
          wb_dat_o <= {24'h000000, pmode, 5'h00};
        end else if (isAddr(wb_adr_i, `CSP_ADDR_PCTRL)) begin
          wb_dat_o <= {24'h000000, 1'b0, sleepBit, stopBit, idleBit, 4'h0};
        end else begin
          wb_dat_o <= 32'h00000000;
        end
      end
    end
  end

  // ==========================================================
  // assertions
  sequence stopWake_s;
    state == CSP_STOP && wakeEvent;
  endsequence

  wake_clears_stop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    stopWake_s |=> !stopBit && system_clock_source_sel.source == 2'b00)
    else $error("stop wake did not clear stop bit");

  osc_off_stop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == CSP_STOP |=> !fastOscEn)
    else $error("fast oscillator on in stop");

  osc_on_wake_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    stopWake_s |=> ##1 fastOscEn)
    else $error("oscillator not restarted on wake");

  idle_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == CSP_IDLE && idleExit |=> !idleBit && state == CSP_RUN)
    else $error("idle bit not cleared on exit");

  idle_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == CSP_IDLE |=> !coreClkEn)
    else $error("core clock runs in idle");

  rsm_rate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    rsmActive && running && coreClkEn && system_clock_source_sel.source == 2'b01 && $stable(pmode)
    |=> (!coreClkEn || !rsmActive) [*8])
    else $error("reduced speed enable too frequent");

  auto_return_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    autoReturn && !wdtReset |=> !rsmActive)
    else $error("auto return did not leave reduced speed");

  sleep_reg_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == CSP_STOP && sleepBit |=> !mainRegEn)
    else $error("regulator on in sleep");

  mask_block_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == CSP_STOP && !asyncRise && !(|(irqRise & stop_wake_source_mask))
    |=> state == CSP_STOP)
    else $error("masked source woke stop");
endmodule : csp_clock_power
`default_nettype wire

/* File: bench/csp_far_side.sv */
`timescale 1ns/100ps
`default_nettype none
// far side: slow oscillator ticks and the wake and switchback sources
module csp_far_side (
  // clock
  input  wire logic       core_clk,
  // sources
  output var  logic       slowTick,
  output var  logic [1:0] extPinIrq,
  output var  logic [5:0] periphIrqFlag,
  output var  logic       asyncWakeIrq,
  output var  logic       primaryUartRx,
  output var  logic       uartTxLoad
);
  logic [1:0] tickCnt = 2'h0;

  initial begin
    extPinIrq = 2'h3;
    periphIrqFlag = 6'h00;
    asyncWakeIrq = 1'b0;
    primaryUartRx = 1'b1;
    uartTxLoad = 1'b0;
  end

  // one slow cycle every four core cycles
  always @(posedge core_clk) begin
    tickCnt <= tickCnt + 2'h1;
  end
  assign slowTick = (tickCnt == 2'h3);

  // 0-1 pins, 2-7 flags, 8 async, 9 rx start bit, 10 tx buffer load
  task automatic fire(input int k);
    @(posedge core_clk);
    if (k < 2) extPinIrq <= extPinIrq & ~(2'h1 << k);
    else if (k < 8) periphIrqFlag <= periphIrqFlag | (6'h01 << (k - 2));
    else if (k == 8) asyncWakeIrq <= 1'b1;
    else if (k == 9) primaryUartRx <= 1'b0;
    else uartTxLoad <= 1'b1;
    @(posedge core_clk);
    uartTxLoad <= 1'b0;
    // levels held well past the input synchronisers
    repeat (6) @(posedge core_clk);
    extPinIrq <= 2'h3;
    periphIrqFlag <= 6'h00;
    asyncWakeIrq <= 1'b0;
    primaryUartRx <= 1'b1;
  endtask : fire
endmodule : csp_far_side
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
  logic [7:0]  wbAdr = 8'h00, irqEn = 8'hff, irqNb = 8'hff;
  logic [3:0]  wbSel = 4'h1;
  logic [31:0] wbDat = 32'h0, rdData;
  logic        wdtReset = 1'b0, rxEn = 1'b1, slowTick, txLoad, rxLine, asyncIrq;
  logic [1:0]  pinIrq;
  logic [5:0]  flagIrq;
  logic        coreClkEn, periphClkEn, fastOscEn, mainRegEn, cpuHold, slowSelected;
  int          fails = 0, n_checks = 0, c, p;
  int          src[6] = '{0, 7, 9, 10, 0, 9};
  logic        en[6] = '{1, 1, 1, 1, 1, 0};
  logic        nb[6] = '{1, 1, 1, 1, 0, 1};

  always #5 core_clk = ~core_clk;

  csp_clock_power i_csp_clock_power (
    .core_clk(core_clk), .rst_n(rst_n), .slowTick(slowTick), .wdtReset(wdtReset),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(rdData), .wb_ack_o(wbAck),
    .extPinIrq(pinIrq), .periphIrqFlag(flagIrq), .irqEnabled(irqEn),
    .irqNotBlocked(irqNb), .asyncWakeIrq(asyncIrq), .primaryUartRx(rxLine),
    .uart0RxEnable(rxEn), .uartTxLoad(txLoad), .coreClkEn(coreClkEn),
    .periphClkEn(periphClkEn), .fastOscEn(fastOscEn), .mainRegEn(mainRegEn),
    .cpuHold(cpuHold), .slowSelected(slowSelected));

  csp_far_side i_csp_far_side (
    .core_clk(core_clk), .slowTick(slowTick), .extPinIrq(pinIrq),
    .periphIrqFlag(flagIrq), .asyncWakeIrq(asyncIrq), .primaryUartRx(rxLine),
    .uartTxLoad(txLoad));

  // ==========================================
  // tasks
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge core_clk);
    chk("ack low", 0, wbAck);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDat <= {24'h0, d};
    // only the watchdog ends a hung transfer
    do begin
      @(posedge core_clk);
    end while (wbAck !== 1'b1);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : wb

  task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
    wb(a, 1'b0, 8'h00);
    chk(n, {24'h0, e}, rdData);
  endtask : rd

  // counts clock enables over n cycles
  task automatic cnt(input int n);
    c = 0;
    p = 0;
    repeat (n) begin
      @(posedge core_clk);
      c += (coreClkEn === 1'b1);
      p += (periphClkEn === 1'b1);
    end
  endtask : cnt

  // counts slow ticks while the cpu is held with the regulator up
  task automatic hold(input int e);
    int t, k;
    t = 0;
    k = 0;
    while (cpuHold !== 1'b0 && t < 3000) begin
      @(posedge core_clk);
      k += ((slowTick & mainRegEn & cpuHold) === 1'b1);
      t++;
    end
    chk("settle", 1, (k >= e - 1) && (k <= e + 1));
  endtask : hold

  // ==========================================
  // tests
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    hold(128);
    rd("system_clock_source_sel", 8'h8f, 8'h00);
    rd("wake", 8'h9f, 8'hff);
    rd("pmode", 8'hc4, 8'h40);
    rd("pctrl", 8'h87, 8'h00);
    rd("unmapped", 8'h10, 8'h00);
    wb(8'h9f, 1'b1, 8'h5a);
    rd("wake", 8'h9f, 8'h5a);
    wbSel <= 4'h0;
    wb(8'h9f, 1'b1, 8'h33);
    wbSel <= 4'h1;
    rd("sel0", 8'h9f, 8'h5a);
    wb(8'h8f, 1'b1, 8'h02);
    @(posedge core_clk);
    chk("slowsel", 1, slowSelected);
    wb(8'h8f, 1'b1, 8'h60);
    cnt(120);
    chk("div12", 10, p);
    wb(8'h8f, 1'b1, 8'h90);
    cnt(128);
    chk("div32", 4, p);
    wb(8'h8f, 1'b1, 8'h01);
    cnt(20);
    chk("fast", 20, c);
    wb(8'hc4, 1'b1, 8'hc0);
    cnt(514);
    chk("rsm core", 2, c);
    chk("rsm periph", 514, p);
    wb(8'hc4, 1'b1, 8'h40);
    cnt(20);
    chk("full", 20, c);
    for (int i = 0; i < 6; i++) begin
      wb(8'hc4, 1'b1, 8'he0);
      irqEn <= {8{en[i]}};
      irqNb <= {8{nb[i]}};
      rxEn <= en[i];
      i_csp_far_side.fire(src[i]);
      rd("autoret", 8'hc4, (en[i] & nb[i]) ? 8'h60 : 8'he0);
    end
    irqEn <= 8'hff;
    irqNb <= 8'hff;
    rxEn <= 1'b1;
    wb(8'hc4, 1'b1, 8'hc0);
    wdtReset <= 1'b1;
    repeat (2) @(posedge core_clk);
    wdtReset <= 1'b0;
    rd("wdt", 8'hc4, 8'h40);
    wb(8'h87, 1'b1, 8'h10);
    @(posedge core_clk);
    cnt(20);
    chk("idle core", 0, c);
    chk("idle periph", 20, p);
    i_csp_far_side.fire(0);
    rd("idle exit", 8'h87, 8'h00);
    wb(8'h8f, 1'b1, 8'h03);
    wb(8'h9f, 1'b1, 8'hfe);
    wb(8'h87, 1'b1, 8'h20);
    @(posedge core_clk);
    cnt(10);
    chk("stop clk", 0, c + p);
    i_csp_far_side.fire(0);
    i_csp_far_side.fire(10);
    chk("stop osc", 0, fastOscEn);
    i_csp_far_side.fire(1);
    chk("wake osc", 1, fastOscEn);
    rd("stop clr", 8'h87, 8'h00);
    chk("src fast", 0, slowSelected);
    wb(8'h87, 1'b1, 8'h60);
    repeat (3) @(posedge core_clk);
    chk("reg off", 0, mainRegEn);
    fork
      i_csp_far_side.fire(8);
      hold(16);
    join
    chk("reg on", 1, mainRegEn);
    wb(8'hc4, 1'b1, 8'hc0);
    rst_n <= 1'b0;
    @(posedge core_clk);
    rst_n <= 1'b1;
    hold(128);
    rd("rst pmode", 8'hc4, 8'h40);
    test_done();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    $display("ERROR watchdog expected done seen timeout");
    test_done();
  end
endmodule : tb_top
`default_nettype wire
